// ### pattern_rom.sv
// mask pattern store: 16 rhythms by 32 beats by 14 outputs
`timescale 1ns/100ps
module pattern_rom #(
    parameter logic [7167:0] CONTENTS = '0
) (
    // address
    input wire logic [rhythm_pkg::NUM_RHYTHMS-1:0] rhythm_on_i,
    input wire logic [rhythm_pkg::BEAT_W-1:0] beat_i,
    // data, one per output, one = pulse
    output logic [rhythm_pkg::NUM_OUTPUTS-1:0] bits_o
);
    logic [rhythm_pkg::NUM_OUTPUTS-1:0] word [rhythm_pkg::NUM_RHYTHMS];

    // word for rhythm r, beat b sits at index r*32+b, bit 0 = lsb output
    genvar r;
    generate
        for (r = 0; r < rhythm_pkg::NUM_RHYTHMS; r++) begin : g_rhythm
            always_comb begin
                word[r] = '0;
                if (rhythm_on_i[r]) begin
                    word[r] = CONTENTS[(r * rhythm_pkg::NUM_BEATS
                        + int'(beat_i)) * rhythm_pkg::NUM_OUTPUTS +:
                        rhythm_pkg::NUM_OUTPUTS]; // RULE1
                end
            end
        end
    endgenerate

    always_comb begin
        bits_o = '0;
        for (int i = 0; i < rhythm_pkg::NUM_RHYTHMS; i++) begin
            bits_o = bits_o | word[i]; // RULE9
        end
    end
endmodule // pattern_rom

// ### pulse_timer.sv
// one-shot down-counter timer used for both strobe widths
`timescale 1ns/100ps
module pulse_timer #(
    parameter int WIDTH_CYC = 150000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic fire_i,
    // status
    output logic busy_o
);
    typedef struct packed {
        logic [rhythm_pkg::WIDTH_CNT_W-1:0] cnt;
        logic busy;
    } timer_state_t;

    localparam logic [rhythm_pkg::WIDTH_CNT_W-1:0] LOAD =
        rhythm_pkg::WIDTH_CNT_W'(WIDTH_CYC - 1);

    timer_state_t st_r;
    timer_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (st_r.busy) begin
            if (st_r.cnt == '0) begin
                st_nxt.busy = 1'b0;
            end else begin
                st_nxt.cnt = st_r.cnt - 1'b1; // RULE16
            end
        end else if (fire_i) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt = LOAD; // RULE16
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy_o = st_r.busy;
endmodule // pulse_timer

// ### rhythm_pattern_rom_sequencer.sv
// top: beat counter, pattern and downbeat strobes of the rhythm generator
`timescale 1ns/100ps
module rhythm_pattern_rom_sequencer #(
    parameter int PATTERN_WIDTH_CYC = rhythm_pkg::PATTERN_WIDTH_CYC,
    parameter int DOWNBEAT_WIDTH_CYC = rhythm_pkg::DOWNBEAT_WIDTH_CYC,
    parameter logic [7167:0] CONTENTS = '0
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // pins from outside, asynchronous
    input wire logic tempo_clk_i,
    input wire logic count_sel_i,
    input wire logic chip_on_i,
    input wire logic [15:0] rhythm_select_n_i,
    // pattern and downbeat outputs
    output logic [13:0] pattern_out_o,
    output logic downbeat_out_o
);
    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        logic [2:0] settle;
        rhythm_pkg::pin_in_t meta;
        rhythm_pkg::pin_in_t pins;
        logic tempo_prev;
        logic [rhythm_pkg::BEAT_W-1:0] beat;
        logic [rhythm_pkg::NUM_OUTPUTS-1:0] latched;
        rhythm_pkg::pin_out_t outs;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;
    // kept apart from st_r: it runs on the raw reset, the rest on its copy
    logic [1:0] rst_sync_r;
    logic rst_sync_n;
    logic [rhythm_pkg::NUM_OUTPUTS-1:0] rom_bits;
    logic fall;
    logic rise;
    logic pat_busy;
    logic db_busy;
    logic pat_fire;
    logic db_fire;
    rhythm_pkg::pin_in_t raw;

    // ****************************************************
    // reset release
    // ****************************************************
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_r <= '0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_r[1];

    // ****************************************************
    // sub-blocks
    // ****************************************************
    pattern_rom #(
        .CONTENTS(CONTENTS)
    ) u_rom (
        .rhythm_on_i(~st_r.pins.rhythm_sel_n),
        .beat_i(st_r.beat),
        .bits_o(rom_bits)
    );

    pulse_timer #(
        .WIDTH_CYC(PATTERN_WIDTH_CYC)
    ) u_pat_timer (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_sync_n),
        .fire_i(pat_fire),
        .busy_o(pat_busy)
    );

    pulse_timer #(
        .WIDTH_CYC(DOWNBEAT_WIDTH_CYC)
    ) u_db_timer (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_sync_n),
        .fire_i(db_fire),
        .busy_o(db_busy)
    );

    // ****************************************************
    // edges and strobe triggers
    // ****************************************************
    // a floating count select is pulled high externally, so high = 32 beats
    assign raw = '{tempo: tempo_clk_i, count_sel: count_sel_i,
                   chip_on: chip_on_i, rhythm_sel_n: rhythm_select_n_i};
    // no edge is taken before the pin stages and tempo_prev hold real samples,
    // so a tempo pin resting high does not look like a rise after reset
    assign rise = st_r.settle[2] & st_r.pins.tempo &
        ~st_r.tempo_prev; // RULE4
    assign fall = st_r.settle[2] & ~st_r.pins.tempo &
        st_r.tempo_prev;
    // pattern strobe starts at each falling edge while on, unless one is still running
    assign pat_fire = fall & st_r.pins.chip_on & ~pat_busy; // RULE17
    assign db_fire = fall & st_r.pins.chip_on & ~db_busy &
        (st_r.beat == rhythm_pkg::BEAT_DOWN_A ||
         st_r.beat == rhythm_pkg::BEAT_DOWN_B); // RULE12

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = raw;
        st_nxt.pins = st_r.meta;
        st_nxt.tempo_prev = st_r.pins.tempo;
        st_nxt.settle = {st_r.settle[1:0], 1'b1};
        if (!st_r.pins.chip_on) begin
            st_nxt.beat = rhythm_pkg::BEAT_ZERO; // RULE6
        end else if (rise) begin
            if (st_r.pins.count_sel) begin // RULE8
                // five bits wrap 31 to 0 naturally
                st_nxt.beat = st_r.beat + 1'b1; // RULE5 RULE3
            end else if (st_r.beat == rhythm_pkg::BEAT_SKIP_FROM) begin
                st_nxt.beat = rhythm_pkg::BEAT_SKIP_TO; // RULE7
            end else if (st_r.beat >= rhythm_pkg::BEAT_LAST_24) begin
                st_nxt.beat = rhythm_pkg::BEAT_ZERO; // RULE7
            end else begin
                st_nxt.beat = st_r.beat + 1'b1; // RULE7
            end
        end
        // capture the beat word at the falling edge, before the next rise
        if (pat_fire) begin
            st_nxt.latched = rom_bits; // RULE9
        end
        // pattern outputs: low for one bits while the strobe runs
        if (pat_busy) begin
            st_nxt.outs.pattern_out = ~st_r.latched; // RULE11 RULE14
        end else begin
            st_nxt.outs.pattern_out = rhythm_pkg::PATTERN_IDLE; // RULE10
        end
        // downbeat timer ignores chip_on once started
        st_nxt.outs.downbeat_out = db_busy; // RULE13 RULE15
    end

    always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_r.meta <= '0;
            st_r.pins <= '0;
            st_r.tempo_prev <= 1'b0;
            st_r.settle <= '0;
            st_r.beat <= rhythm_pkg::BEAT_ZERO;
            st_r.latched <= '0;
            st_r.outs.pattern_out <= rhythm_pkg::PATTERN_IDLE;
            st_r.outs.downbeat_out <= rhythm_pkg::DOWNBEAT_IDLE;
        end else begin
            st_r.meta <= st_nxt.meta;
            st_r.pins <= st_nxt.pins;
            st_r.tempo_prev <= st_nxt.tempo_prev;
            st_r.settle <= st_nxt.settle;
            st_r.beat <= st_nxt.beat;
            st_r.latched <= st_nxt.latched;
            st_r.outs <= st_nxt.outs;
        end
    end

    assign pattern_out_o = st_r.outs.pattern_out;
    assign downbeat_out_o = st_r.outs.downbeat_out;
endmodule // rhythm_pattern_rom_sequencer

// ### rhythm_pkg.sv
// package: constants, types and field layout for the rhythm pattern sequencer
// Function
// RULE1: fixed 512-bit store per output, 16 rhythms by 32 beats, 14 outputs
// RULE2: controller drives one active-low rhythm select low, others high
// RULE3: 5-bit beat counter addresses the beat; rhythm repeats while on
// RULE4: beat counter advances on each rising tempo clock edge
// RULE5: 32-beat mode counts 0 through 31 then wraps to 0
// RULE6: switching the chip off forces the beat counter to zero
// RULE7: beat count select low runs 0-11, jumps to 16, runs to 27, back to 0
// RULE8: unconnected beat count select reads high, giving 32-beat mode
// RULE9: several selected rhythms are ORed bit by bit
// RULE10: 14 pattern outputs idle high and stay high for zero bits
// RULE11: a one bit pulls the output low at falling tempo edge for pulse width
// RULE12: downbeat idles low, pulses high at falling edge on count 0 or 16
// RULE13: a downbeat pulse in progress completes even if the chip turns off
// RULE14: pattern pulse width is 6 ms per 0.1 uF strobe capacitance
// RULE15: downbeat pulse width is 120 ms per 0.1 uF, separate timer
// RULE16: both widths are down-counters of the system clock from parameters
// RULE17: chip-on input gates operation; no new pulses while off
package rhythm_pkg;
    // ****************************************************
    // geometry
    // ****************************************************
    localparam int NUM_OUTPUTS = 14;
    localparam int NUM_RHYTHMS = 16;
    localparam int NUM_BEATS = 32;
    localparam int BEAT_W = 5;
    localparam int RHYTHM_W = 4;

    // ****************************************************
    // beat counter sequence points
    // ****************************************************
    localparam logic [4:0] BEAT_ZERO = 5'h00;
    localparam logic [4:0] BEAT_LAST_32 = 5'h1F;
    localparam logic [4:0] BEAT_SKIP_FROM = 5'h0B;
    localparam logic [4:0] BEAT_SKIP_TO = 5'h10;
    localparam logic [4:0] BEAT_LAST_24 = 5'h1B;
    localparam logic [4:0] BEAT_DOWN_A = 5'h00;
    localparam logic [4:0] BEAT_DOWN_B = 5'h10;

    // ****************************************************
    // timing: nominal widths with 0.1 uF, system clock rate
    // ****************************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int PATTERN_WIDTH_MS = 6;
    localparam int DOWNBEAT_WIDTH_MS = 120;
    localparam int PATTERN_WIDTH_CYC = PATTERN_WIDTH_MS * (CLK_HZ / 1000);
    localparam int DOWNBEAT_WIDTH_CYC = DOWNBEAT_WIDTH_MS * (CLK_HZ / 1000);
    localparam int WIDTH_CNT_W = 32;

    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic [13:0] PATTERN_IDLE = 14'h3FFF;
    localparam logic DOWNBEAT_IDLE = 1'b0;

    // ****************************************************
    // carriers
    // ****************************************************
    typedef struct packed {
        logic tempo;
        logic count_sel;
        logic chip_on;
        logic [NUM_RHYTHMS-1:0] rhythm_sel_n;
    } pin_in_t;

    typedef struct packed {
        logic [NUM_OUTPUTS-1:0] pattern_out;
        logic downbeat_out;
    } pin_out_t;
endpackage

// ### rhythm_seq_chk.sv
// checker: port-level timing of the rhythm sequencer strobes
`timescale 1ns/100ps
module rhythm_seq_chk #(
    parameter int PATTERN_WIDTH_CYC = 4,
    parameter int DOWNBEAT_WIDTH_CYC = 10
) (
    // clock, reset and pins in
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic tempo_clk_i,
    input wire logic count_sel_i,
    input wire logic chip_on_i,
    input wire logic [15:0] rhythm_select_n_i,
    // strobes out
    input wire logic [13:0] pattern_out_o,
    input wire logic downbeat_out_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic pat_idle = &pattern_out_o;
    int pat_cnt;
    int db_cnt;
    // run lengths, judged at the edge where each pulse ends
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pat_cnt <= 0;
            db_cnt <= 0;
        end else begin
            pat_cnt <= pat_idle ? 0 : pat_cnt + 1;
            db_cnt <= downbeat_out_o ? db_cnt + 1 : 0;
        end
    end
    rst_idle_a: assert property (
        $rose(rst_n_i) |-> pat_idle && !downbeat_out_o) else $error("busy");
    pat_width_a: assert property (
        $rose(pat_idle) |-> pat_cnt == PATTERN_WIDTH_CYC) else $error("pw");
    db_width_a: assert property (
        $fell(downbeat_out_o) |-> db_cnt == DOWNBEAT_WIDTH_CYC)
        else $error("dw");
    // the strobe fires on the chip-on level seen four edges before it shows
    pat_on_fall_a: assert property (
        $fell(pat_idle) |-> !tempo_clk_i && $past(chip_on_i, 4))
        else $error("pattern start");
    db_on_fall_a: assert property (
        $rose(downbeat_out_o) |-> !tempo_clk_i && ($fell(pat_idle) || pat_idle))
        else $error("downbeat start");
    pat_hold_a: assert property (
        !pat_idle && !$past(pat_idle) |-> $stable(pattern_out_o))
        else $error("pattern moved");
    off_quiet_a: assert property (
        (!chip_on_i) [*8] |-> !$fell(pat_idle) && !$rose(downbeat_out_o))
        else $error("pulse while off");
    pat_gap_a: assert property (
        $rose(pat_idle) |=> pat_idle [*3]) else $error("retrigger");
    none_sel_a: assert property (
        (&rhythm_select_n_i) [*8] |-> !$fell(pat_idle))
        else $error("pulse with no rhythm selected");
endmodule // rhythm_seq_chk

bind rhythm_pattern_rom_sequencer rhythm_seq_chk #(
    .PATTERN_WIDTH_CYC(PATTERN_WIDTH_CYC),
    .DOWNBEAT_WIDTH_CYC(DOWNBEAT_WIDTH_CYC)
) i_rhythm_seq_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tempo_clk_i(tempo_clk_i),
    .count_sel_i(count_sel_i), .chip_on_i(chip_on_i),
    .rhythm_select_n_i(rhythm_select_n_i),
    .pattern_out_o(pattern_out_o), .downbeat_out_o(downbeat_out_o)
);

// ### tb_rhythm_pattern_rom_sequencer.sv
// testbench: beat-level model and checks for the rhythm sequencer
`timescale 1ns/100ps
module tb_rhythm_pattern_rom_sequencer;
    localparam int PW = 4;
    localparam int DW = 10;
    function automatic logic [7167:0] mk_rom();
        logic [7167:0] v;
        v = '0;
        // every fifth word blank so idle beats are seen too
        for (int i = 0; i < 512; i++) begin
            if (i % 5 != 0) v[i*14 +: 14] = 14'(i * 40503 ^ (i >> 3));
        end
        return v;
    endfunction
    localparam logic [7167:0] ROM = mk_rom();
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, count_sel_i = 1'b1;
    logic chip_on_i = 1'b1, run = 1'b0, tempo, db;
    logic [15:0] sel = 16'h0001, rsel_n;
    logic [13:0] pat;
    logic [4:0] beat = 5'h00;
    rhythm_pkg::pin_out_t expq[$];
    int bad_count = 0, n_tests = 0;
    rhythm_pattern_rom_sequencer #(
        .PATTERN_WIDTH_CYC(PW), .DOWNBEAT_WIDTH_CYC(DW), .CONTENTS(ROM)
    ) i_rhythm_pattern_rom_sequencer (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tempo_clk_i(tempo),
        .count_sel_i(count_sel_i), .chip_on_i(chip_on_i),
        .rhythm_select_n_i(rsel_n), .pattern_out_o(pat), .downbeat_out_o(db)
    );
    tempo_src #(.HALF(20)) i_tempo_src (.clk_i(ref_clk_i), .run_i(run),
        .sel_i(sel), .tempo_o(tempo), .rsel_n_o(rsel_n));
    initial forever #20 ref_clk_i = ~ref_clk_i;
    task automatic check(input rhythm_pkg::pin_out_t s, e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task report_and_stop;
        if (bad_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // returns three clocks after the tempo pin falls n times
    task automatic beats(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            while (tempo !== 1'b1 && k < 99) begin
                @(posedge ref_clk_i);
                k++;
            end
            while (tempo !== 1'b0 && k < 99) begin
                @(posedge ref_clk_i);
                k++;
            end
            if (k >= 99) begin
                bad_count++;
                report_and_stop();
            end
            repeat (2) @(posedge ref_clk_i);
        end
    endtask
    always @(posedge tempo) begin
        if (rst_n_i !== 1'b1 || !chip_on_i) beat = 5'h00;
        else if (!count_sel_i && beat == 5'h0B) beat = 5'h10;
        else if (!count_sel_i && beat >= 5'h1B) beat = 5'h00;
        else beat = beat + 5'h01;
    end
    always @(negedge tempo) begin
        logic [13:0] w;
        w = 14'h0000;
        for (int r = 0; r < 16; r++) begin
            if (!rsel_n[r]) w = w | ROM[(r*32+beat)*14 +: 14];
        end
        if (rst_n_i === 1'b1 && chip_on_i)
            expq.push_back({~w, beat == 5'h00 || beat == 5'h10});
        else if (rst_n_i === 1'b1)
            expq.push_back({14'h3FFF, 1'b0});
    end
    always @(negedge tempo) begin
        rhythm_pkg::pin_out_t e;
        if (rst_n_i === 1'b1) begin
            repeat (6) @(posedge ref_clk_i);
            #1;
            // an empty queue leaves e unknown, so the check reports it
            e = 'x;
            if (expq.size() != 0) e = expq.pop_front();
            check({pat, db}, e);
        end
    end
    initial begin
        int k;
        void'($urandom(42918));
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        run <= 1'b1;
        for (int r = 0; r < 32; r++) begin
            sel <= 16'h0001 << (r % 16);
            beats(2);
        end
        // no rhythm selected: outputs stay idle on beats 1 and 2, no downbeat due
        sel <= 16'h0000;
        beats(2);
        for (int i = 0; i < 6; i++) begin
            sel <= 16'($urandom);
            beats(4);
        end
        count_sel_i <= 1'b0;
        beats(30);
        k = 0;
        while (beat != 5'h10 && k < 40) begin
            beats(1);
            k++;
        end
        if (k >= 40) begin
            bad_count++;
            report_and_stop();
        end
        chip_on_i <= 1'b0;
        beats(3);
        chip_on_i <= 1'b1;
        count_sel_i <= 1'b1;
        beats(6);
        run <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        report_and_stop();
    end
endmodule // tb_rhythm_pattern_rom_sequencer

// ### tempo_src.sv
// partner: tempo source and rhythm select drive of the organ side
`timescale 1ns/100ps
module tempo_src #(
    parameter int HALF = 20
) (
    // clock and control
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [15:0] sel_i,
    // pins toward the sequencer
    output logic tempo_o,
    output logic [15:0] rsel_n_o
);
    logic tempo_r = 1'b0;
    int cnt = 0;
    // low half far longer than the strobe, so no strobe is cut short
    always @(posedge clk_i) begin
        rsel_n_o <= ~sel_i;
        if (run_i) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) tempo_r <= ~tempo_r;
        end
    end
    assign tempo_o = tempo_r;
endmodule // tempo_src
